//--- hw/alarm_timing_pkg.sv
// Constants and carrier types for the alarm and sample timing block.
// Assumes a 20 MHz clock and 16-bit serial frames from the host.
package alarm_timing_pkg;

   // Register offsets (even byte of each 16-bit register)
   localparam logic [5:0] ADDR_WINDOW  = 6'h26;
   localparam logic [5:0] ADDR_CONTROL = 6'h28;
   localparam logic [5:0] ADDR_PERIOD  = 6'h36;

   // Reset values
   localparam logic [15:0] WINDOW_RST  = 16'h0000;
   localparam logic [15:0] CONTROL_RST = 16'h0000;
   localparam logic [7:0]  PERIOD_RST  = 8'h0A;

   // Control register fields
   localparam int CTL_ROC2     = 15;
   localparam int CTL_SRC2_LSB = 12;
   localparam int CTL_ROC1     = 11;
   localparam int CTL_SRC1_LSB = 8;
   localparam int CTL_EN       = 2;
   localparam int CTL_POL      = 1;
   localparam int CTL_PIN      = 0;
   localparam logic [15:0] CONTROL_MASK = 16'hFF07;

   // Period and magnitude fields, source codes
   localparam int PRD_BASE  = 7;
   localparam int MAG_ABOVE = 15;
   localparam logic [2:0] SRC_OFF    = 3'h0;
   localparam logic [2:0] SRC_SUPPLY = 3'h1;
   localparam logic [2:0] SRC_AUX    = 3'h4;

   // Serial frame layout
   localparam int FRAME_BITS = 16;
   localparam int FRM_WRITE  = 15;
   localparam int FRM_A_LSB  = 8;

   // Time bases, least times rounded up to whole cycles
   localparam int CLOCK_NS      = 50;
   localparam int BASE_SHORT_NS = 122100;
   localparam int BASE_LONG_NS  = 3784000;
   localparam int BASE_SHORT_CYC =
      (BASE_SHORT_NS + CLOCK_NS - 1) / CLOCK_NS;
   localparam int BASE_LONG_CYC =
      (BASE_LONG_NS + CLOCK_NS - 1) / CLOCK_NS;

   typedef logic [13:0] sample_type;

   // Seven outputs sampled as one group; index is source code minus one
   typedef struct packed {
      logic                 ready;
      logic [6:0][13:0]     value;
   } sample_set_type;

   // Two-way pin: level and enable
   typedef struct packed {
      logic out;
      logic oe;
   } pin_drive_type;

endpackage : alarm_timing_pkg

//--- hw/spi_frame_port.sv
// Serial port slave: 16-bit frames, clock idles high, data in on rise.
// Assumes pins already synchronous to clock and sclk far below clock.
`timescale 1ns/1ns
`default_nettype none
module spi_frame_port
   import alarm_timing_pkg::*;
(
   input  wire logic          clock,
   input  wire logic          nrst,
   input  wire logic          cs_n,
   input  wire logic          sclk,
   input  wire logic          mosi,
   input  wire logic [15:0]   reply,
   output logic               frame_valid,
   output logic [15:0]        frame,
   output logic               miso,
   output logic               miso_oe
);
   typedef struct packed {
      logic        sclk_prev;
      logic [3:0]  cnt;
      logic [15:0] shift_in;
      logic [15:0] shift_out;
      logic        valid;
      logic [15:0] frame;
   } port_state_type;

   port_state_type s_q, s_d;

   // Shift in on rising edges, out on falling edges after the first
   always_comb begin
      s_d = s_q;
      s_d.valid = 1'b0;
      s_d.sclk_prev = sclk;
      if (cs_n) begin
         s_d.cnt = 4'h0;
         s_d.shift_out = reply;
      end else if (sclk && !s_q.sclk_prev) begin
         s_d.shift_in = {s_q.shift_in[14:0], mosi};
         s_d.cnt = s_q.cnt + 4'h1;
         if (s_q.cnt == 4'(FRAME_BITS - 1)) begin
            s_d.valid = 1'b1;
            s_d.frame = {s_q.shift_in[14:0], mosi};
         end
      end else if (!sclk && s_q.sclk_prev && s_q.cnt != 4'h0) begin
         s_d.shift_out = {s_q.shift_out[14:0], 1'b0};
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_q <= '{sclk_prev: 1'b1, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   assign frame_valid = s_q.valid;
   assign frame       = s_q.frame;
   assign miso        = s_q.shift_out[15];
   assign miso_oe     = !cs_n;
endmodule : spi_frame_port
`default_nettype wire

//--- hw/period_timer.sv
// Sample period timer: one strobe every time base times (count + 1).
// Assumes the setting byte is held in a register of the caller.
`timescale 1ns/1ns
`default_nettype none
module period_timer
   import alarm_timing_pkg::*;
#(
   parameter int LONG_CYC = BASE_LONG_CYC
)(
   input  wire logic          clock,
   input  wire logic          nrst,
   input  wire logic [7:0]    setting,
   output logic               strobe
);
   if (LONG_CYC < BASE_SHORT_CYC || LONG_CYC > 131071) begin : g_chk
      $error("period_timer: LONG_CYC out of range");
   end

   typedef struct packed {
      logic [16:0] base_cnt;
      logic [6:0]  unit_cnt;
      logic        strobe;
   } timer_state_type;

   timer_state_type s_q, s_d;
   logic [16:0] limit;

   // Time base picked each cycle; a lowered count ends the period early
   always_comb begin
      limit = setting[PRD_BASE] ? 17'(LONG_CYC - 1)
                                : 17'(BASE_SHORT_CYC - 1);
      s_d = s_q;
      s_d.strobe = 1'b0;
      s_d.base_cnt = s_q.base_cnt + 17'h1;
      if (s_q.base_cnt >= limit) begin
         s_d.base_cnt = 17'h0;
         if (s_q.unit_cnt >= setting[6:0]) begin
            s_d.unit_cnt = 7'h0;
            s_d.strobe = 1'b1;
         end else begin
            s_d.unit_cnt = s_q.unit_cnt + 7'h1;
         end
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign strobe = s_q.strobe;

   // Helper: cycles since last strobe; steady flag cleared when setting moves
   logic [23:0] gap_q;
   logic        steady_q;
   logic [7:0]  set_q;
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         gap_q <= 24'h0;
         steady_q <= 1'b0;
         set_q <= 8'h0;
      end else begin
         set_q <= setting;
         gap_q <= strobe ? 24'h1 : gap_q + 24'h1;
         if (setting != set_q) steady_q <= 1'b0;
         else if (strobe) steady_q <= 1'b1;
      end
   end

   period_len_a: assert property (@(posedge clock) disable iff (!nrst)
      strobe && steady_q && setting == set_q |->
      gap_q == 24'((32'(limit) + 1) * (32'(setting[6:0]) + 1)))
      else $error("sample period length wrong");
endmodule : period_timer
`default_nettype wire

//--- hw/alarm_and_sample_timing.sv
// Alarm configuration, alarm evaluation and sample period timing.
// Assumes raw samples arrive on samples.ready after each strobe,
// magnitudes and alarm one window come from neighbouring registers.
`timescale 1ns/1ns
`default_nettype none
module alarm_and_sample_timing
   import alarm_timing_pkg::*;
#(
   parameter int LONG_BASE_CYC = BASE_LONG_CYC
)(
   input  wire logic                            clock,
   input  wire logic                            nrst,
   input  wire logic                            npower_on,
   input  wire logic                            spi_cs_n,
   input  wire logic                            spi_sclk,
   input  wire logic                            spi_mosi,
   output logic                                 spi_miso,
   output logic                                 spi_miso_oe,
   input  wire logic                            flash_update,
   input  wire logic [15:0]                     alarm_one_magnitude,
   input  wire logic [15:0]                     alarm_two_magnitude,
   input  wire logic [7:0]                      alarm_one_window,
   input  wire alarm_timing_pkg::sample_set_type samples,
   output logic                                 sample_strobe,
   output alarm_timing_pkg::pin_drive_type      general_pin_zero,
   output alarm_timing_pkg::pin_drive_type      general_pin_one,
   output logic [1:0]                           alarm_status
);
   import alarm_timing_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // State

   typedef struct packed {
      logic            restore;
      logic [7:0]      window;
      logic [15:0]     control;
      logic [7:0]      period;
      logic [5:0]      read_addr;
      logic            ctl_written;
      logic [1:0]      hit;
      logic [1:0][7:0] cnt;
      logic [1:0][13:0] ref_val;
      logic [1:0]      ref_ok;
      pin_drive_type   pin0;
      pin_drive_type   pin1;
   } main_state_type;

   // Nonvolatile copies: cleared only by a power cycle
   typedef struct packed {
      logic [7:0] window;
      logic [7:0] period;
      logic       saved;
   } nv_state_type;

   main_state_type s_q, s_d;
   nv_state_type   nv_q, nv_d;

   logic        frame_valid;
   logic [15:0] frame;
   logic [15:0] reply;
   logic        wr;
   logic [5:0]  wr_addr;
   logic [7:0]  wr_byte;

   ////////////////////////////////////////////////////////////////////
   // Host port and period timer

   spi_frame_port u_port (
      .clock       (clock),
      .nrst        (nrst),
      .cs_n        (spi_cs_n),
      .sclk        (spi_sclk),
      .mosi        (spi_mosi),
      .reply       (reply),
      .frame_valid (frame_valid),
      .frame       (frame),
      .miso        (spi_miso),
      .miso_oe     (spi_miso_oe)
   );

   // One strobe starts a group conversion of all seven outputs
   period_timer #(
      .LONG_CYC (LONG_BASE_CYC)
   ) u_timer (
      .clock   (clock),
      .nrst    (nrst),
      .setting (s_q.period),
      .strobe  (sample_strobe)
   );

   // Frame decode: write bit, byte address, data byte
   assign wr      = frame_valid && frame[FRM_WRITE];
   assign wr_addr = frame[FRM_A_LSB +: 6];
   assign wr_byte = frame[7:0];

   // Read mux for the next frame; unused bits read zero
   always_comb begin
      case (s_q.read_addr)
         ADDR_WINDOW:  reply = {8'h00, s_q.window};
         ADDR_CONTROL: reply = s_q.control & CONTROL_MASK;
         ADDR_PERIOD:  reply = {8'h00, s_q.period};
         default:      reply = 16'h0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Alarm evaluation helpers

   logic [1:0][2:0]  src;
   logic [1:0]       rate_of_change_mode;
   logic [1:0][15:0] mag;
   logic [1:0][7:0]  win;
   logic [1:0]       src_on;
   logic [1:0]       thr_hit;
   logic [1:0]       roc_hit;
   logic [1:0]       roc_end;
   logic [1:0][13:0] cur;
   logic [1:0][14:0] cur_x;
   logic [1:0][14:0] lim_x;
   logic [1:0][14:0] ref_x;
   logic [1:0][23:0] delta;
   logic [1:0][23:0] lim_n;
   logic             alarm_on;
   logic             level;

   // Field extraction: index 0 is alarm one, index 1 is alarm two
   assign src[1] = s_q.control[CTL_SRC2_LSB +: 3];
   assign src[0] = s_q.control[CTL_SRC1_LSB +: 3];
   assign rate_of_change_mode[1] = s_q.control[CTL_ROC2];
   assign rate_of_change_mode[0] = s_q.control[CTL_ROC1];
   assign mag[1] = alarm_two_magnitude;
   assign mag[0] = alarm_one_magnitude;
   assign win[1] = s_q.window;
   assign win[0] = alarm_one_window;

   // Compare signed unless the source is a plain binary reading;
   // raw samples only, so averaging never delays an alarm
   always_comb begin
      for (int k = 0; k < 2; k++) begin
         src_on[k] = src[k] != SRC_OFF;
         cur[k] = src_on[k] ? samples.value[3'(src[k] - 3'h1)]
                            : 14'h0000;
         if (src[k] == SRC_SUPPLY || src[k] == SRC_AUX) begin
            cur_x[k] = {1'b0, cur[k]};
            lim_x[k] = {1'b0, mag[k][13:0]};
            ref_x[k] = {1'b0, s_q.ref_val[k]};
         end else begin
            cur_x[k] = {cur[k][13], cur[k]};
            lim_x[k] = {mag[k][13], mag[k][13:0]};
            ref_x[k] = {s_q.ref_val[k][13], s_q.ref_val[k]};
         end
         thr_hit[k] = mag[k][MAG_ABOVE]
            ? $signed(cur_x[k]) > $signed(lim_x[k])
            : $signed(cur_x[k]) < $signed(lim_x[k]);
         // Change over the window against magnitude times window size,
         // which equals the averaged change without a divider
         // Operands widened first so the product never loses top bits
         delta[k] = 24'($signed(cur_x[k])) - 24'($signed(ref_x[k]));
         lim_n[k] = 24'($signed(lim_x[k])) *
            24'($signed({1'b0, (win[k] == 8'h00) ? 8'h01 : win[k]}));
         roc_hit[k] = mag[k][MAG_ABOVE]
            ? $signed(delta[k]) > $signed(lim_n[k])
            : $signed(delta[k]) < $signed(lim_n[k]);
         roc_end[k] = s_q.cnt[k] + 8'h01 >= win[k];
      end
   end

   // Shared pin level; inactive when disabled or nothing selected
   assign alarm_on = s_q.control[CTL_EN] && |(s_q.hit & src_on);
   assign level    = alarm_on ~^ s_q.control[CTL_POL];

   ////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      s_d  = s_q;
      nv_d = nv_q;
      // Restore from nonvolatile copies right after reset release
      if (s_q.restore) begin
         s_d.restore = 1'b0;
         s_d.window  = nv_q.window;
         s_d.period  = nv_q.saved ? nv_q.period : PERIOD_RST;
      end
      if (frame_valid && !frame[FRM_WRITE]) begin
         s_d.read_addr = {wr_addr[5:1], 1'b0};
      end
      // Byte writes: even address is the low byte
      if (wr) begin
         case (wr_addr)
            ADDR_WINDOW: begin
               s_d.window  = wr_byte;
               nv_d.window = wr_byte;
            end
            ADDR_CONTROL: begin
               s_d.control[7:0] = wr_byte & CONTROL_MASK[7:0];
               s_d.ctl_written = 1'b1;
            end
            ADDR_CONTROL + 6'h1: begin
               s_d.control[15:8] = wr_byte;
               s_d.ctl_written = 1'b1;
            end
            ADDR_PERIOD: begin
               s_d.period = wr_byte;
            end
            default: begin
            end
         endcase
      end
      // Manual flash update makes the period survive reset
      if (flash_update) begin
         nv_d.period = s_q.period;
         nv_d.saved  = 1'b1;
      end
      // Threshold alarms are re-judged on each fresh group of samples, rate alarms at window end
      if (samples.ready) begin
         for (int k = 0; k < 2; k++) begin
            if (!src_on[k]) begin
               s_d.hit[k] = 1'b0;
               s_d.ref_ok[k] = 1'b0;
               s_d.cnt[k] = 8'h00;
            end else if (!rate_of_change_mode[k]) begin
               s_d.hit[k] = thr_hit[k];
               s_d.ref_ok[k] = 1'b0;
               s_d.cnt[k] = 8'h00;
            end else if (roc_end[k]) begin
               // First window after a mode change only takes a base
               s_d.hit[k] = s_q.ref_ok[k] && roc_hit[k];
               s_d.ref_val[k] = cur[k];
               s_d.ref_ok[k] = 1'b1;
               s_d.cnt[k] = 8'h00;
            end else begin
               s_d.cnt[k] = s_q.cnt[k] + 8'h01;
            end
         end
      end
      // Route the level; the unused pin is released to other owners
      s_d.pin0.out = level;
      s_d.pin1.out = level;
      s_d.pin0.oe = s_q.control[CTL_EN] && !s_q.control[CTL_PIN];
      s_d.pin1.oe = s_q.control[CTL_EN] && s_q.control[CTL_PIN];
   end

   ////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         s_q <= '0;
         s_q.restore <= 1'b1;
         s_q.control <= CONTROL_RST;
         s_q.window  <= WINDOW_RST[7:0];
         s_q.period  <= PERIOD_RST;
         s_q.pin0.out <= 1'b1;
         s_q.pin1.out <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Copies kept across host reset, lost only with power
   always_ff @(posedge clock or negedge npower_on) begin
      if (!npower_on) begin
         nv_q <= '0;
      end else begin
         nv_q <= nv_d;
      end
   end

   assign general_pin_zero = s_q.pin0;
   assign general_pin_one  = s_q.pin1;
   assign alarm_status     = s_q.hit & src_on;

   ////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   sequence window_write_s;
      wr && wr_addr == ADDR_WINDOW;
   endsequence

   sequence threshold_sample_s(int k);
      samples.ready && src_on[k] && !rate_of_change_mode[k];
   endsequence

   window_upper_a: assert property (
      s_q.read_addr == ADDR_WINDOW |-> reply[15:8] == 8'h00)
      else $error("window upper byte not zero");

   control_default_a: assert property (
      !s_q.ctl_written |-> s_q.control == CONTROL_RST)
      else $error("control moved before any write");

   window_nv_a: assert property (
      window_write_s |=> nv_q.window == $past(wr_byte)
                         && s_q.window == nv_q.window)
      else $error("window not kept in nonvolatile copy");

   thr_two_a: assert property (
      threshold_sample_s(1) |=> s_q.hit[1] == $past(thr_hit[1]))
      else $error("alarm two threshold result wrong");

   thr_one_follow_a: assert property (
      threshold_sample_s(0) ##1 src_on[0] |->
      alarm_status[0] == $past(thr_hit[0]))
      else $error("alarm one does not follow its sample");

   source_off_a: assert property (
      samples.ready && !src_on[1] |=> !s_q.hit[1])
      else $error("alarm two active with source off");

   pin_level_a: assert property (
      s_q.control[CTL_EN] && $stable(s_q.control) |=>
      general_pin_zero.out ==
      ($past(alarm_on) ~^ $past(s_q.control[CTL_POL])))
      else $error("alarm pin level or polarity wrong");

   pin_route_a: assert property (
      ##1 s_q.control[CTL_EN] && $stable(s_q.control) |->
      general_pin_one.oe == s_q.control[CTL_PIN]
      && general_pin_zero.oe == !s_q.control[CTL_PIN])
      else $error("alarm pin routed to wrong pin");

   pin_idle_a: assert property (
      !s_q.control[CTL_EN] && $stable(s_q.control) |=>
      general_pin_zero.out == !$past(s_q.control[CTL_POL]))
      else $error("disabled alarm pin not inactive");

   period_restore_a: assert property (
      s_q.restore && !nv_q.saved |=> s_q.period == PERIOD_RST)
      else $error("period not default after reset");

endmodule : alarm_and_sample_timing
`default_nettype wire

//--- dv/spi_host_model.sv
// Host side of the serial port: sends 16-bit frames, clock idles high.
// Assumes the device samples data on sclk rise and shifts on sclk fall.
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
   input  wire logic clock,
   input  wire logic spi_miso,
   output logic      spi_cs_n,
   output logic      spi_sclk,
   output logic      spi_mosi
);
   ////////////////////////////////////////////////////////////////////////
   // Idle: deselected, serial clock parked high
   initial begin
      spi_cs_n = 1'b1;
      spi_sclk = 1'b1;
      spi_mosi = 1'b0;
   end
   // One frame, MSB first; at least four clocks a phase so the device sees each edge
   task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
      @(posedge clock) spi_cs_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         @(posedge clock) spi_sclk <= 1'b0;
         spi_mosi <= tx[i];
         repeat (4) @(posedge clock);
         spi_sclk <= 1'b1;
         rx[i] = spi_miso;
         repeat (4) @(posedge clock);
      end
      spi_cs_n <= 1'b1;
      spi_mosi <= ~spi_mosi; // Released line never shows stale data
      repeat (4) @(posedge clock); // Gap lets the reply reload
   endtask : xfer
endmodule : spi_host_model
`default_nettype wire

//--- dv/alarm_and_sample_timing_tb.sv
// Self-checking bench: registers over the serial port, timer, alarm pins.
// Assumes the host model above and a shortened long time base.
`timescale 1ns/1ns
`default_nettype none
module alarm_and_sample_timing_tb;
   import alarm_timing_pkg::*;
   localparam int LONG = 3000;
   logic           clock, nrst, npower_on, flash_update, sample_strobe;
   logic           spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe;
   logic [15:0]    mag_one, mag_two, ctl, rd;
   logic [7:0]     win_one, set;
   logic [1:0]     alarm_status, hits;
   logic [1:0][13:0] last;
   sample_set_type samples;
   pin_drive_type  pin_zero, pin_one, sel, other;
   int             fails, comparisons, seed, n;

   alarm_and_sample_timing #(.LONG_BASE_CYC(LONG))
      alarm_and_sample_timing_inst (
      .clock(clock), .nrst(nrst), .npower_on(npower_on),
      .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
      .flash_update(flash_update), .alarm_one_magnitude(mag_one),
      .alarm_two_magnitude(mag_two), .alarm_one_window(win_one),
      .samples(samples), .sample_strobe(sample_strobe),
      .general_pin_zero(pin_zero), .general_pin_one(pin_one),
      .alarm_status(alarm_status));
   spi_host_model spi_host_model_inst (
      .clock(clock), .spi_miso(spi_miso), .spi_cs_n(spi_cs_n),
      .spi_sclk(spi_sclk), .spi_mosi(spi_mosi));

   ////////////////////////////////////////////////////////////////////////
   // Clock and helpers
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   task automatic check(input logic [15:0] got, exp, input string what);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t %s: %h not %h", $time, what, got, exp);
      end
   endtask : check
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      spi_host_model_inst.xfer({2'b10, a, d}, rd);
   endtask : wr
   // Read answer arrives in the following frame
   task automatic rdchk(input logic [5:0] a, input logic [15:0] exp);
      spi_host_model_inst.xfer({2'b00, a, 8'h00}, rd);
      spi_host_model_inst.xfer(16'h0000, rd);
      check(rd, exp, "register");
   endtask : rdchk
   // Power flag also clears the nonvolatile copies
   task automatic restart(input logic power);
      @(posedge clock) nrst <= 1'b0;
      npower_on <= ~power;
      repeat (10) @(posedge clock);
      nrst <= 1'b1;
      npower_on <= 1'b1;
      repeat (3) @(posedge clock);
   endtask : restart
   task automatic feed();
      for (int k = 0; k < 7; k++)
         samples.value[k] <= 14'($random(seed));
      samples.ready <= 1'b1;
      @(posedge clock) samples.ready <= 1'b0;
      repeat (3) @(posedge clock);
   endtask : feed
   // Counted on falling edges so the registered strobe is settled
   task automatic gap(output int c);
      c = 0;
      do begin
         @(negedge clock);
         c++;
      end while (sample_strobe !== 1'b1 && c < 20000);
   endtask : gap
   function automatic int expect_gap(input logic [7:0] s);
      return (s[7] ? LONG : BASE_SHORT_CYC) * (int'(s[6:0]) + 1);
   endfunction : expect_gap
   // Supply and auxiliary are unsigned, the rest two's complement
   function automatic logic hit(input logic [2:0] c, input logic [15:0] m);
      logic [13:0] v;
      if (c == SRC_OFF) return 1'b0;
      v = samples.value[c - 3'h1];
      if (c == SRC_SUPPLY || c == SRC_AUX)
         return m[MAG_ABOVE] ? v > m[13:0] : v < m[13:0];
      return m[MAG_ABOVE] ? $signed(v) > $signed(m[13:0])
                          : $signed(v) < $signed(m[13:0]);
   endfunction : hit
   // Change since the reference against magnitude times window
   function automatic logic rate_of_change_mode(input logic [2:0] c, input logic [15:0] m,
                                input int w, input logic [13:0] a, b);
      int d, l;
      if (c == SRC_SUPPLY || c == SRC_AUX) begin
         d = int'(a) - int'(b);
         l = int'(m[13:0]) * w;
      end else begin
         d = int'($signed(a)) - int'($signed(b));
         l = int'($signed(m[13:0])) * w;
      end
      return m[MAG_ABOVE] ? d > l : d < l;
   endfunction : rate_of_change_mode
   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop

   ////////////////////////////////////////////////////////////////////////
   // Watchdog: the whole sequence needs well under this many cycles
   initial begin
      repeat (60000) @(posedge clock);
      fails++;
      report_and_stop();
   end
   initial begin
      {nrst, npower_on, flash_update, samples} = '0;
      {mag_one, mag_two, win_one} = '0;
      {fails, comparisons} = '0;
      seed = 32'hF44A;
      restart(1'b1);
      check(16'(spi_miso_oe), 16'h0000, "miso enable");
      rdchk(ADDR_WINDOW, WINDOW_RST);
      rdchk(ADDR_CONTROL, CONTROL_RST);
      rdchk(ADDR_PERIOD, {8'h00, PERIOD_RST});
      rdchk(6'h30, 16'h0000);
      $display("test defaults done");
      // Upper byte ignored; window survives reset, period only after flash
      set = 8'($random(seed));
      wr(ADDR_WINDOW, set);
      wr(ADDR_WINDOW + 6'h01, 8'hFF);
      rdchk(ADDR_WINDOW, {8'h00, set});
      wr(ADDR_PERIOD, 8'h05);
      restart(1'b0);
      rdchk(ADDR_WINDOW, {8'h00, set});
      rdchk(ADDR_PERIOD, 16'h000A);
      wr(ADDR_PERIOD, 8'h85);
      @(posedge clock) flash_update <= 1'b1;
      @(posedge clock) flash_update <= 1'b0;
      restart(1'b0);
      rdchk(ADDR_PERIOD, 16'h0085);
      restart(1'b1);
      rdchk(ADDR_WINDOW, 16'h0000);
      $display("test storage done");
      // Second gap avoids the partial period left by the change
      for (int i = 0; i < 3; i++) begin
         set = (i == 2) ? 8'h81 : 8'(i);
         wr(ADDR_PERIOD, set);
         gap(n);
         gap(n);
         check(16'(n), 16'(expect_gap(set)), "strobe gap");
      end
      $display("test timer done");
      // Rate mode: alarm one judged each sample (window 0 acts as 1),
      // alarm two each second one; first window only takes a reference
      wr(ADDR_WINDOW, 8'h02);
      wr(ADDR_CONTROL, 8'h06);
      wr(ADDR_CONTROL + 6'h01, 8'hA9);
      mag_one <= 16'($random(seed));
      mag_two <= 16'($random(seed));
      win_one <= 8'h00;
      hits = 2'b00;
      for (int f = 0; f < 8; f++) begin
         feed();
         if (f > 0)
            hits[0] = rate_of_change_mode(SRC_SUPPLY, mag_one, 1, samples.value[0], last[0]);
         if (f % 2 == 1 && f > 1)
            hits[1] = rate_of_change_mode(3'h2, mag_two, 2, samples.value[1], last[1]);
         check(16'(alarm_status), 16'(hits), "rate");
         last[0] = samples.value[0];
         if (f % 2 == 1) last[1] = samples.value[1];
      end
      $display("test rate done");
      // Every alarm two source, random alarm one source, pin and polarity
      for (int t = 0; t < 16; t++) begin
         ctl = {1'b0, 3'(t), 1'b0, 3'($random(seed)), 8'($random(seed))};
         wr(ADDR_CONTROL, ctl[7:0]);
         wr(ADDR_CONTROL + 6'h01, ctl[15:8]);
         rdchk(ADDR_CONTROL, ctl & CONTROL_MASK);
         mag_one <= 16'($random(seed));
         mag_two <= 16'($random(seed));
         win_one <= 8'($random(seed));
         feed();
         hits = {hit(ctl[14:12], mag_two), hit(ctl[10:8], mag_one)};
         check(16'(alarm_status), 16'(hits), "status");
         sel = ctl[CTL_PIN] ? pin_one : pin_zero;
         other = ctl[CTL_PIN] ? pin_zero : pin_one;
         check(16'(sel), {14'h0, (ctl[2] & |hits) ~^ ctl[1], ctl[2]},
               "alarm pin");
         check(16'(other.oe), 16'h0000, "other pin");
      end
      $display("test alarms done");
      report_and_stop();
   end
endmodule : alarm_and_sample_timing_tb
`default_nettype wire
